// [rtl/ccr_pkg.sv]
/*
 * ccr_pkg: shared constants for the comparator control register bank.
 * assumes: a 32-bit avalon-mm slave with byte addresses; 8-bit registers
 * sit in the low byte of each word, upper bits read as zero.
 */
package ccr_pkg;

	// ************************************************************
	// bus layout
	// ************************************************************
	localparam int CCR_ADDR_W = 6;
	localparam int CCR_DATA_W = 32;
	localparam int CCR_REG_W = 8;
	localparam int CCR_MAX_CH = 4;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [CCR_ADDR_W-1:0] CCR_OFS_CTRL_A = 6'h00;
	localparam logic [CCR_ADDR_W-1:0] CCR_OFS_CTRL_B = 6'h04;
	localparam logic [CCR_ADDR_W-1:0] CCR_CH_STRIDE = 6'h08;
	localparam logic [CCR_ADDR_W-1:0] CCR_OFS_EDGE = 6'h20;
	localparam logic [CCR_ADDR_W-1:0] CCR_OFS_STATUS = 6'h24;
	localparam logic [CCR_ADDR_W-1:0] CCR_OFS_MASK = 6'h28;

	// ************************************************************
	// control a fields
	// ************************************************************
	localparam int CCR_A_RESULT = 7;
	localparam int CCR_A_MODE = 6;
	localparam int CCR_A_REFSEL = 5;
	localparam int CCR_A_TRIM_HI = 4;
	localparam int CCR_A_TRIM_LO = 0;
	localparam int CCR_TRIM_W = 5;
	localparam logic [CCR_REG_W-1:0] CCR_CTRL_A_RST = 8'h10;

	// ************************************************************
	// control b fields
	// ************************************************************
	localparam int CCR_B_NONINV = 7;
	localparam int CCR_B_IRQEN = 3;
	localparam int CCR_B_PINEN = 2;
	localparam int CCR_B_INV = 1;
	localparam int CCR_B_POWER = 0;
	localparam logic [CCR_REG_W-1:0] CCR_CTRL_B_RST = 8'h82;

	// ************************************************************
	// interrupt edge selection
	// ************************************************************
	localparam int CCR_EDGE_W = 2;
	localparam logic [CCR_EDGE_W-1:0] CCR_EDGE_OFF = 2'h0;
	localparam logic [CCR_EDGE_W-1:0] CCR_EDGE_RISE = 2'h1;
	localparam logic [CCR_EDGE_W-1:0] CCR_EDGE_FALL = 2'h2;
	localparam logic [CCR_EDGE_W-1:0] CCR_EDGE_BOTH = 2'h3;

	// ************************************************************
	// bus handshake states
	// ************************************************************
	typedef enum logic [0:0] {
		CCR_BUS_IDLE = 1'b0,
		CCR_BUS_DONE = 1'b1
	} ccr_bus_e;

endpackage

// [rtl/ccr_chan.sv]
/*
 * ccr_chan: result path of one comparator channel.
 * assumes: raw_in comes straight from the analog core, asynchronous to clk_in.
 */
`timescale 1ns/1ns
`default_nettype none

module ccr_chan
	import ccr_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// analog side
	input wire logic raw_in,
	// synchronised result and edges
	output logic result_out,
	output logic rise_out,
	output logic fall_out
);

	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;
	logic prev_reg;
	logic prev_next;

	// ************************************************************
	// two-stage synchroniser and edge detector
	// ************************************************************
	always_comb
	begin
		meta_next = raw_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// edges compare the second stage with its own delayed copy only
	assign result_out = sync_reg;
	assign rise_out = sync_reg & ~prev_reg;
	assign fall_out = ~sync_reg & prev_reg;

endmodule // ccr_chan

`default_nettype wire

// [rtl/ccr_regs.sv]
/*
 * ccr_regs: control and status registers for a set of analog comparators.
 * assumes: avalon-mm master on clk_in; comparator results arrive asynchronously;
 * the shared output pin is released to normal i/o when not driven here.
 */
`timescale 1ns/1ns
`default_nettype none

module ccr_regs
	import ccr_pkg::*;
#(
	parameter int NUM_CH = 2
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// avalon-mm slave
	input wire logic [CCR_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [CCR_DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [CCR_DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// interrupt
	output logic irq_out,
	// analog comparator core
	input wire logic [NUM_CH-1:0] compare_raw_in,
	output logic [NUM_CH-1:0] compare_power_enable_out,
	output logic [NUM_CH-1:0] offset_cancel_mode_out,
	output logic [NUM_CH-1:0] trim_reference_select_out,
	output logic [NUM_CH*CCR_TRIM_W-1:0] offset_trim_code_out,
	output logic [NUM_CH-1:0] noninv_path_select_out,
	output logic [NUM_CH-1:0] inv_path_select_out,
	// shared output pin
	output logic [NUM_CH-1:0] compare_pin_out,
	output logic [NUM_CH-1:0] compare_pin_oe_n_out
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (NUM_CH < 1 || NUM_CH > CCR_MAX_CH)
	begin : g_bad_num_ch
		$error("NUM_CH must lie between 1 and 4");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	ccr_bus_e bus_reg;
	ccr_bus_e bus_next;
	logic [CCR_DATA_W-1:0] rdata_reg;
	logic [CCR_DATA_W-1:0] rdata_next;
	logic [NUM_CH-1:0] mode_reg;
	logic [NUM_CH-1:0] mode_next;
	logic [NUM_CH-1:0] refsel_reg;
	logic [NUM_CH-1:0] refsel_next;
	logic [CCR_TRIM_W-1:0] trim_reg [NUM_CH];
	logic [CCR_TRIM_W-1:0] trim_next [NUM_CH];
	logic [NUM_CH-1:0] noninv_reg;
	logic [NUM_CH-1:0] noninv_next;
	logic [NUM_CH-1:0] irqen_reg;
	logic [NUM_CH-1:0] irqen_next;
	logic [NUM_CH-1:0] pinen_reg;
	logic [NUM_CH-1:0] pinen_next;
	logic [NUM_CH-1:0] inv_reg;
	logic [NUM_CH-1:0] inv_next;
	logic [NUM_CH-1:0] power_reg;
	logic [NUM_CH-1:0] power_next;
	logic [CCR_EDGE_W-1:0] edge_reg [NUM_CH];
	logic [CCR_EDGE_W-1:0] edge_next [NUM_CH];
	logic [NUM_CH-1:0] status_reg;
	logic [NUM_CH-1:0] status_next;
	logic [NUM_CH-1:0] mask_reg;
	logic [NUM_CH-1:0] mask_next;
	logic [NUM_CH-1:0] pin_reg;
	logic [NUM_CH-1:0] pin_next;
	logic [NUM_CH-1:0] pin_oe_n_reg;
	logic [NUM_CH-1:0] pin_oe_n_next;
	logic [NUM_CH-1:0] result;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] fall;
	logic [NUM_CH-1:0] event_hit;
	logic req;
	logic fire_wr;
	logic lane0;
	logic [CCR_REG_W-1:0] wbyte;

	// ************************************************************
	// per-channel result path
	// ************************************************************
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_chan
		ccr_chan u_chan (
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.raw_in(compare_raw_in[c]),
			.result_out(result[c]),
			.rise_out(rise[c]),
			.fall_out(fall[c])
		);
	end

	// ************************************************************
	// avalon handshake
	// ************************************************************
	// one wait state: the read word is registered in the first cycle and the
	// write lands on the edge where waitrequest is seen low.
	assign req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & (bus_reg == CCR_BUS_IDLE);
	assign fire_wr = avs_write_in & (bus_reg == CCR_BUS_DONE);
	assign lane0 = avs_byteenable_in[0];
	assign wbyte = avs_writedata_in[CCR_REG_W-1:0];

	always_comb
	begin
		bus_next = CCR_BUS_IDLE;
		case (bus_reg)
			CCR_BUS_IDLE:
			begin
				if (req)
				begin
					bus_next = CCR_BUS_DONE;
				end
			end
			CCR_BUS_DONE:
			begin
				bus_next = CCR_BUS_IDLE;
			end
			default:
			begin
				bus_next = CCR_BUS_IDLE;
			end
		endcase
	end

	// ************************************************************
	// read mux
	// ************************************************************
	always_comb
	begin
		rdata_next = rdata_reg;
		if (avs_read_in && bus_reg == CCR_BUS_IDLE)
		begin
			// unmapped or misaligned addresses read as zero
			rdata_next = '0;
			for (int c = 0; c < NUM_CH; c++)
			begin
				if (avs_address_in == CCR_OFS_CTRL_A + CCR_ADDR_W'(c) * CCR_CH_STRIDE)
				begin
					rdata_next[CCR_A_RESULT] = result[c];
					rdata_next[CCR_A_MODE] = mode_reg[c];
					rdata_next[CCR_A_REFSEL] = refsel_reg[c];
					rdata_next[CCR_A_TRIM_HI:CCR_A_TRIM_LO] = trim_reg[c];
				end
				if (avs_address_in == CCR_OFS_CTRL_B + CCR_ADDR_W'(c) * CCR_CH_STRIDE)
				begin
					// forced selects read one during cancellation
					rdata_next[CCR_B_NONINV] = noninv_reg[c] | mode_reg[c];
					rdata_next[CCR_B_IRQEN] = irqen_reg[c];
					rdata_next[CCR_B_PINEN] = pinen_reg[c];
					rdata_next[CCR_B_INV] = inv_reg[c] | mode_reg[c];
					rdata_next[CCR_B_POWER] = power_reg[c];
					// bits six to four are left zero
				end
				if (avs_address_in == CCR_OFS_EDGE)
				begin
					rdata_next[CCR_EDGE_W*c +: CCR_EDGE_W] = edge_reg[c];
				end
			end
			if (avs_address_in == CCR_OFS_STATUS)
			begin
				rdata_next[NUM_CH-1:0] = status_reg;
			end
			if (avs_address_in == CCR_OFS_MASK)
			begin
				rdata_next[NUM_CH-1:0] = mask_reg;
			end
		end
	end

	// ************************************************************
	// control register writes
	// ************************************************************
	always_comb
	begin
		mode_next = mode_reg;
		refsel_next = refsel_reg;
		trim_next = trim_reg;
		noninv_next = noninv_reg;
		irqen_next = irqen_reg;
		pinen_next = pinen_reg;
		inv_next = inv_reg;
		power_next = power_reg;
		edge_next = edge_reg;
		mask_next = mask_reg;
		if (fire_wr && lane0)
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				if (avs_address_in == CCR_OFS_CTRL_A + CCR_ADDR_W'(c) * CCR_CH_STRIDE)
				begin
					// the result bit has no storage, so writes cannot touch it
					mode_next[c] = wbyte[CCR_A_MODE];
					refsel_next[c] = wbyte[CCR_A_REFSEL];
					trim_next[c] = wbyte[CCR_A_TRIM_HI:CCR_A_TRIM_LO];
				end
				if (avs_address_in == CCR_OFS_CTRL_B + CCR_ADDR_W'(c) * CCR_CH_STRIDE)
				begin
					// stored selects keep the software value through calibration
					noninv_next[c] = wbyte[CCR_B_NONINV];
					irqen_next[c] = wbyte[CCR_B_IRQEN];
					pinen_next[c] = wbyte[CCR_B_PINEN];
					inv_next[c] = wbyte[CCR_B_INV];
					power_next[c] = wbyte[CCR_B_POWER];
				end
				if (avs_address_in == CCR_OFS_EDGE)
				begin
					edge_next[c] = wbyte[CCR_EDGE_W*c +: CCR_EDGE_W];
				end
			end
			if (avs_address_in == CCR_OFS_MASK)
			begin
				mask_next = wbyte[NUM_CH-1:0];
			end
		end
	end

	// ************************************************************
	// interrupt status
	// ************************************************************
	always_comb
	begin
		status_next = status_reg;
		for (int c = 0; c < NUM_CH; c++)
		begin
			case (edge_reg[c])
				CCR_EDGE_OFF: event_hit[c] = 1'b0;
				CCR_EDGE_RISE: event_hit[c] = rise[c];
				CCR_EDGE_FALL: event_hit[c] = fall[c];
				CCR_EDGE_BOTH: event_hit[c] = rise[c] | fall[c];
				default: event_hit[c] = 1'b0;
			endcase
			event_hit[c] = event_hit[c] & irqen_reg[c];
		end
		if (fire_wr && lane0 && avs_address_in == CCR_OFS_STATUS)
		begin
			status_next = status_reg & ~wbyte[NUM_CH-1:0];
		end
		// a new edge wins over a clear in the same cycle
		status_next = status_next | event_hit;
	end

	// ************************************************************
	// analog and pin drive
	// ************************************************************
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			pin_next[c] = result[c] & pinen_reg[c];
			pin_oe_n_next[c] = ~pinen_reg[c];
		end
	end

	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			offset_trim_code_out[CCR_TRIM_W*c +: CCR_TRIM_W] = trim_reg[c];
		end
	end

	assign compare_power_enable_out = power_reg;
	assign offset_cancel_mode_out = mode_reg;
	assign trim_reference_select_out = refsel_reg;
	assign noninv_path_select_out = noninv_reg | mode_reg;
	assign inv_path_select_out = inv_reg | mode_reg;
	assign compare_pin_out = pin_reg;
	assign compare_pin_oe_n_out = pin_oe_n_reg;
	assign avs_readdata_out = rdata_reg;
	assign irq_out = |(status_reg & mask_reg);

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			bus_reg <= CCR_BUS_IDLE;
			rdata_reg <= '0;
			mode_reg <= {NUM_CH{CCR_CTRL_A_RST[CCR_A_MODE]}};
			refsel_reg <= {NUM_CH{CCR_CTRL_A_RST[CCR_A_REFSEL]}};
			noninv_reg <= {NUM_CH{CCR_CTRL_B_RST[CCR_B_NONINV]}};
			irqen_reg <= {NUM_CH{CCR_CTRL_B_RST[CCR_B_IRQEN]}};
			pinen_reg <= {NUM_CH{CCR_CTRL_B_RST[CCR_B_PINEN]}};
			inv_reg <= {NUM_CH{CCR_CTRL_B_RST[CCR_B_INV]}};
			power_reg <= {NUM_CH{CCR_CTRL_B_RST[CCR_B_POWER]}};
			status_reg <= '0;
			mask_reg <= '0;
			pin_reg <= '0;
			pin_oe_n_reg <= '1;
			for (int c = 0; c < NUM_CH; c++)
			begin
				trim_reg[c] <= CCR_CTRL_A_RST[CCR_A_TRIM_HI:CCR_A_TRIM_LO];
				edge_reg[c] <= CCR_EDGE_OFF;
			end
		end
		else
		begin
			bus_reg <= bus_next;
			rdata_reg <= rdata_next;
			mode_reg <= mode_next;
			refsel_reg <= refsel_next;
			noninv_reg <= noninv_next;
			irqen_reg <= irqen_next;
			pinen_reg <= pinen_next;
			inv_reg <= inv_next;
			power_reg <= power_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			pin_reg <= pin_next;
			pin_oe_n_reg <= pin_oe_n_next;
			trim_reg <= trim_next;
			edge_reg <= edge_next;
		end
	end

endmodule // ccr_regs

`default_nettype wire

// [verification/ccr_regs_chk.sv]
/*
 * ccr_regs_chk: port-level checks on the comparator register bank.
 * assumes: bound onto ccr_regs; one clock domain, async active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none

module ccr_regs_chk
	import ccr_pkg::*;
#(
	parameter int NUM_CH = 2
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// avalon-mm slave
	input wire logic [CCR_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [CCR_DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [CCR_DATA_W-1:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic irq_out,
	// analog side and pin
	input wire logic [NUM_CH-1:0] compare_raw_in,
	input wire logic [NUM_CH-1:0] compare_power_enable_out,
	input wire logic [NUM_CH-1:0] offset_cancel_mode_out,
	input wire logic [NUM_CH-1:0] trim_reference_select_out,
	input wire logic [NUM_CH*CCR_TRIM_W-1:0] offset_trim_code_out,
	input wire logic [NUM_CH-1:0] noninv_path_select_out,
	input wire logic [NUM_CH-1:0] inv_path_select_out,
	input wire logic [NUM_CH-1:0] compare_pin_out,
	input wire logic [NUM_CH-1:0] compare_pin_oe_n_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic done;
	assign done = (avs_read_in || avs_write_in) && !avs_waitrequest_out;

	a_wait_first: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("no answer after one wait state");
	a_one_wait: assert property (done |-> $past(avs_waitrequest_out))
		else $error("answer without a wait state");
	a_b_gap: assert property (done && avs_read_in && avs_address_in == CCR_OFS_CTRL_B
		|-> avs_readdata_out[6:4] == 3'h0) else $error("gap bits of control b not zero");
	a_mode_forces: assert property (
		(offset_cancel_mode_out & ~(noninv_path_select_out & inv_path_select_out)) == '0)
		else $error("path selects not forced in cancel mode");
	a_mode_readback: assert property (done && avs_read_in && avs_address_in == CCR_OFS_CTRL_B
		&& $past(offset_cancel_mode_out[0]) |-> avs_readdata_out[7] && avs_readdata_out[1])
		else $error("forced selects not read as one");
	a_cfg_by_write: assert property ($changed({compare_power_enable_out,
		offset_cancel_mode_out, trim_reference_select_out, offset_trim_code_out})
		|-> $past(avs_write_in && !avs_waitrequest_out)) else $error("control moved without write");
	a_pin_idle: assert property (compare_pin_oe_n_out[0] |-> !compare_pin_out[0])
		else $error("pin data while released");
	a_pin_follow: assert property (!compare_pin_oe_n_out[0] && $past(!compare_pin_oe_n_out[0])
		|-> compare_pin_out[0] == $past(compare_raw_in[0], 3)) else $error("pin not result");
endmodule // ccr_regs_chk

bind ccr_regs ccr_regs_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.irq_out(irq_out), .compare_raw_in(compare_raw_in),
	.compare_power_enable_out(compare_power_enable_out),
	.offset_cancel_mode_out(offset_cancel_mode_out),
	.trim_reference_select_out(trim_reference_select_out),
	.offset_trim_code_out(offset_trim_code_out), .noninv_path_select_out(noninv_path_select_out),
	.inv_path_select_out(inv_path_select_out), .compare_pin_out(compare_pin_out),
	.compare_pin_oe_n_out(compare_pin_oe_n_out));

`default_nettype wire

// [verification/ccr_analog_model.sv]
/*
 * ccr_analog_model: behavioural two-channel comparator core.
 * assumes: bench sets the input difference per channel; trip code is a plain default.
 */
`timescale 1ns/1ns
`default_nettype none

module ccr_analog_model
	import ccr_pkg::*;
#(
	parameter logic [CCR_TRIM_W-1:0] TRIP_CODE = 5'h13
)
(
	// controls from the register bank
	input wire logic [1:0] power_in,
	input wire logic [1:0] cancel_in,
	input wire logic [2*CCR_TRIM_W-1:0] trim_in,
	// input difference, high when plus is above minus
	input wire logic [1:0] level_in,
	// decisions, asynchronous to the bank clock
	output logic [1:0] raw_out
);
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			// a powered-down core holds low rather than floating
			raw_out[c] = 1'b0;
			if (power_in[c])
				raw_out[c] = cancel_in[c] ? (trim_in[c*5 +: 5] >= TRIP_CODE) : level_in[c];
		end
	end
endmodule // ccr_analog_model

`default_nettype wire

// [verification/tb_comparator_control_regs.sv]
/*
 * tb_comparator_control_regs: register-sequence tests of ccr_regs.
 * assumes: ccr_analog_model closes the loop from controls to raw results.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_comparator_control_regs;
	import ccr_pkg::*;
	localparam logic [4:0] TRIP = 5'h0b;
	localparam logic [5:0] A0 = CCR_OFS_CTRL_A;
	localparam logic [5:0] B0 = CCR_OFS_CTRL_B;
	logic clk_in, reset_n_in, bus_rd, bus_wr;
	logic [5:0] bus_addr;
	logic [31:0] bus_wdata, rdat, avs_readdata_out;
	logic [3:0] bus_be;
	logic [1:0] level, raw, pwr, mode, rsel, npath, ipath, pin, pin_oe_n;
	logic [9:0] trim;
	logic avs_waitrequest_out, irq_out;
	int n_fail, tests_run, cycles, found;

	ccr_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(bus_addr),
		.avs_read_in(bus_rd), .avs_write_in(bus_wr), .avs_writedata_in(bus_wdata),
		.avs_byteenable_in(bus_be), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .compare_raw_in(raw),
		.compare_power_enable_out(pwr), .offset_cancel_mode_out(mode),
		.trim_reference_select_out(rsel), .offset_trim_code_out(trim),
		.noninv_path_select_out(npath), .inv_path_select_out(ipath), .compare_pin_out(pin),
		.compare_pin_oe_n_out(pin_oe_n));
	ccr_analog_model #(.TRIP_CODE(TRIP)) u_core (.power_in(pwr), .cancel_in(mode),
		.trim_in(trim), .level_in(level), .raw_out(raw));

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			n_fail++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one avalon transfer; holds everything until waitrequest is seen low
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_addr <= a;
		bus_wdata <= {24'h0, d};
		bus_wr <= w;
		bus_rd <= !w;
		// only the bench timeout ends a hung wait, so a hang is counted
		do
		begin
			@(posedge clk_in);
		end
		while (avs_waitrequest_out !== 1'b0);
		rdat = avs_readdata_out;
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rdat, e);
	endtask

	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	initial
	begin
		{reset_n_in, bus_rd, bus_wr, bus_addr, bus_wdata, level, cycles} = '0;
		{n_fail, tests_run} = '0;
		bus_be = 4'h1;
		repeat (5) @(posedge clk_in);
		reset_n_in <= 1'b1;
		for (int c = 0; c < 2; c++)
		begin
			rdc(A0 + 6'(8*c), 32'h10);
			rdc(B0 + 6'(8*c), 32'h82);
		end
		rdc(CCR_OFS_EDGE, 32'h0);
		rdc(CCR_OFS_STATUS, 32'h0);
		rdc(CCR_OFS_MASK, 32'h0);
		rdc(6'h3c, 32'h0);
		chk({pwr, pin_oe_n, trim}, {2'b00, 2'b11, 10'h210});
		wr(B0, 8'hff);
		rdc(B0, 32'h8f);
		wr(A0, 8'hbf);
		rdc(A0, 32'h3f);
		rdc(A0 + 6'h08, 32'h10);
		wr(B0, 8'h01);
		wr(A0, 8'h50);
		rdc(B0, 32'h83);
		chk({mode[0], npath[0], ipath[0]}, 3'b111);
		wr(A0, 8'h30);
		rdc(B0, 32'h01);
		chk({npath[0], ipath[0], rsel[0]}, 3'b001);
		found = 99;
		for (int t = 0; t < 32 && found == 99; t++)
		begin
			wr(A0, 8'h40 | 8'(t));
			hold(4);
			xfer(1'b0, A0, 8'h00);
			if (rdat[7] === 1'b1)
				found = t;
		end
		chk(32'(found), 32'(TRIP));
		chk(trim[4:0], TRIP);
		wr(A0, {3'b000, TRIP});
		wr(B0, 8'h05);
		level <= 2'b01;
		hold(5);
		rdc(A0, {24'h0, 3'b100, TRIP});
		chk({pin_oe_n[0], pin[0]}, 2'b01);
		level <= 2'b00;
		hold(5);
		chk({pin_oe_n[0], pin[0]}, 2'b00);
		wr(B0, 8'h01);
		// pin drive is registered from the stored enable, one cycle behind it
		hold(1);
		chk({pin_oe_n[0], pin[0]}, 2'b10);
		for (int e = 0; e < 4; e++)
		begin
			wr(CCR_OFS_EDGE, 8'(e));
			rdc(CCR_OFS_EDGE, 32'(e));
			wr(B0, 8'h09);
			wr(CCR_OFS_MASK, 8'h01);
			level <= 2'b01;
			hold(5);
			chk(irq_out, e[0]);
			rdc(CCR_OFS_STATUS, 32'(e[0]));
			wr(CCR_OFS_STATUS, 8'h01);
			level <= 2'b00;
			hold(5);
			chk(irq_out, e[1]);
			rdc(CCR_OFS_STATUS, 32'(e[1]));
			wr(CCR_OFS_STATUS, 8'h01);
		end
		wr(CCR_OFS_MASK, 8'h00);
		level <= 2'b01;
		hold(5);
		chk(irq_out, 1'b0);
		rdc(CCR_OFS_STATUS, 32'h1);
		wr(CCR_OFS_MASK, 8'h01);
		chk(irq_out, 1'b1);
		wr(CCR_OFS_STATUS, 8'h01);
		chk(irq_out, 1'b0);
		wr(B0, 8'h01);
		level <= 2'b00;
		hold(5);
		rdc(CCR_OFS_STATUS, 32'h0);
		@(posedge clk_in);
		bus_be <= 4'h0;
		wr(B0, 8'h09);
		bus_be <= 4'h1;
		rdc(B0, 32'h01);
		wr(B0 + 6'h08, 8'h01);
		level <= 2'b10;
		hold(5);
		rdc(A0 + 6'h08, 32'h90);
		rdc(A0, {24'h0, 3'b000, TRIP});
		test_done();
	end
endmodule // tb_comparator_control_regs

`default_nettype wire
